// File: include/ecq_defs.vh
// Constants of the event counter and two-phase channel
`ifndef ECQ_DEFS_VH
`define ECQ_DEFS_VH

`define ECQ_CNT_W        16
`define ECQ_CNT_RST      16'h0000
`define ECQ_CNT_MAX      16'hffff
`define ECQ_CNT_MIN      16'h0000
`define ECQ_TRG_PIN      2'h0
`define ECQ_TRG_COMP     2'h1
`define ECQ_TRG_PREV     2'h2
`define ECQ_TRG_NEXT     2'h3
`define ECQ_CHAN_NORMAL  3'h2
`define ECQ_CHAN_SELECT  3'h3
`define ECQ_CHAN_X4      3'h4
`define ECQ_FLAG_RST     1'h0
`define ECQ_DIR_RST      1'h1
`define ECQ_CNT_STEP     16'h0001

`endif

// File: rtl/ecq_counter.v
// Event counter channel with two-phase pulse decoding
`timescale 1ns/1ps
`include "ecq_defs.vh"
// How it works
// - Trigger select 00b counts pin edges; others count companion/neighbour events.
// - Single-phase pin counting uses only the software-chosen active edge.
// - Direction by software or aux pin: low counts down, high counts up.
// - Reload mode loads reload register on overflow or underflow, keeps counting.
// - Free-running mode just wraps and continues without reload.
// - Overflow every FFFFh-n+1 up counts, underflow every n+1 down counts.
// - Counting happens only while run bit is one.
// - Interrupt request pulses on each overflow or underflow.
// - Count register read returns present counter value.
// - Write while stopped or before first event sets reload and counter.
// - Write after first event sets only reload; applied at next reload.
// - Pulse output toggles on overflow/underflow, low while run bit is zero.
// - Two-phase counting only on channels three to five, using both pins.
// - Normal two-phase: up on rising, down on falling, aux pin high.
// - Times-four: input rising with aux high counts all edges up.
// - Times-four: input falling with aux high counts all edges down.
// - Fourth channel selects processing; third normal, fifth times-four.
// - Fourth channel two-phase: index input clears the counter.
// - Index clear armed by writing 0000h and enable; clears at next count.
module ecq_counter #(
   parameter CHANNEL = 3                  // Channel number, 0 to 4
) (
   input  wire        I_CLOCK,            // Clock, 50 MHz
   input  wire        I_RST,              // Synchronous reset, active high
   input  wire        I_COUNT_INPUT_PIN,  // Count input / phase A pin
   input  wire        I_AUX_PHASE_PIN,    // Aux pin / phase B / direction
   input  wire        I_INDEX_PIN,        // Index (Z-phase) input
   input  wire        I_INDEX_POL,        // Index edge: 1 rising, 0 falling
   input  wire        I_CHANNEL_RUN_BIT,  // Run bit, 1 counts
   input  wire [1:0]  I_TRIGGER_SELECT,   // Count source select
   input  wire        I_EDGE_FALLING,     // Pin active edge: 1 falling
   input  wire        I_DIR_BY_PIN,       // Direction from aux pin
   input  wire        I_DIR_UP,           // Software direction, 1 up
   input  wire        I_FREE_RUN,         // Free-running, no reload
   input  wire        I_PULSE_OUT_EN,     // Pulse output enable
   input  wire        I_TWO_PHASE_ENABLE, // Two-phase processing enable
   input  wire        I_QUAD_MODE_SELECT, // Fourth channel: 1 times-four
   input  wire        I_INDEX_CLEAR_ENABLE, // Index clear enable
   input  wire        I_COMP_EVENT,       // Companion timer over/underflow
   input  wire        I_PREV_EVENT,       // Preceding channel over/underflow
   input  wire        I_NEXT_EVENT,       // Following channel over/underflow
   input  wire        I_WR_STB,           // Count register write strobe
   input  wire [15:0] I_WR_DATA,          // Count register write data
   output wire [15:0] O_COUNT_VALUE_REG,  // Present counter value
   output wire [15:0] O_RELOAD,           // Reload register
   output wire        O_IRQ,              // Interrupt request pulse
   output wire        O_EVENT,            // Over/underflow pulse
   output wire        O_PULSE_OUT         // Pulse output pin level
);

   // ---------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------
   localparam NPIN    = 3;
   localparam PIN_CNT = 0;
   localparam PIN_AUX = 1;
   localparam PIN_IDX = 2;

   wire [NPIN-1:0] pin_raw;
   wire [NPIN-1:0] pin_lvl;
   wire [NPIN-1:0] pin_rise;
   wire [NPIN-1:0] pin_fall;

   assign pin_raw[PIN_CNT] = I_COUNT_INPUT_PIN;
   assign pin_raw[PIN_AUX] = I_AUX_PHASE_PIN;
   assign pin_raw[PIN_IDX] = I_INDEX_PIN;

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
         ecq_sync u_sync (
            .i_clk   (I_CLOCK),
            .i_rst   (I_RST),
            .i_pin   (pin_raw[gi]),
            .o_level (pin_lvl[gi]),
            .o_rise  (pin_rise[gi]),
            .o_fall  (pin_fall[gi])
         );
      end
   endgenerate

   wire a_rise = pin_rise[PIN_CNT];
   wire a_fall = pin_fall[PIN_CNT];
   wire b_lvl  = pin_lvl[PIN_AUX];
   wire b_rise = pin_rise[PIN_AUX];
   wire b_fall = pin_fall[PIN_AUX];
   wire z_rise = pin_rise[PIN_IDX];
   wire z_fall = pin_fall[PIN_IDX];

   // ---------------------------------------------
   // Helper functions
   // ---------------------------------------------
   // Picks one edge of a pin, the falling one when sel_fall is set
   function edge_pick;
      input sel_fall;
      input rise;
      input fall;
      begin
         edge_pick = sel_fall ? fall : rise;
      end
   endfunction

   // Counter stands at the end of its range for this direction
   function at_limit;
      input [15:0] value;
      input        up;
      begin
         if (up)
            at_limit = (value == `ECQ_CNT_MAX);
         else
            at_limit = (value == `ECQ_CNT_MIN);
      end
   endfunction

   // One count step up or down, wrapping at either end
   function [15:0] count_step;
      input [15:0] value;
      input        up;
      begin
         if (up)
            count_step = value + `ECQ_CNT_STEP;
         else
            count_step = value - `ECQ_CNT_STEP;
      end
   endfunction

   // ---------------------------------------------
   // Mode decode
   // ---------------------------------------------
   localparam HAS_2PH = (CHANNEL >= `ECQ_CHAN_NORMAL) &&
                        (CHANNEL <= `ECQ_CHAN_X4);

   wire two_ph = I_TWO_PHASE_ENABLE && HAS_2PH &&
                 (I_TRIGGER_SELECT == `ECQ_TRG_PIN);
   wire use_x4 = (CHANNEL == `ECQ_CHAN_X4) ||
                 ((CHANNEL == `ECQ_CHAN_SELECT) &&
                  I_QUAD_MODE_SELECT);

   // Times-four direction: B leads A counts up, A leads B counts down
   reg x4_dir_reg;
   reg x4_dir_next;
   always @* begin
      x4_dir_next = x4_dir_reg;
      if (a_rise && b_lvl)
         x4_dir_next = 1'b1;
      else if (a_fall && b_lvl)
         x4_dir_next = 1'b0;
   end

   // ---------------------------------------------
   // Count event and direction
   // ---------------------------------------------
   reg cnt_evt;
   reg cnt_up;
   always @* begin
      cnt_evt = 1'b0;
      cnt_up  = 1'b1;
      if (two_ph) begin
         if (use_x4) begin
            cnt_evt = a_rise | a_fall | b_rise | b_fall;
            cnt_up  = x4_dir_next;
         end else begin
            cnt_evt = (a_rise | a_fall) & b_lvl;
            cnt_up  = a_rise;
         end
      end else begin
         case (I_TRIGGER_SELECT)
            `ECQ_TRG_PIN:
               cnt_evt = edge_pick(I_EDGE_FALLING, a_rise, a_fall);
            `ECQ_TRG_COMP: cnt_evt = I_COMP_EVENT;
            `ECQ_TRG_PREV: cnt_evt = I_PREV_EVENT;
            `ECQ_TRG_NEXT: cnt_evt = I_NEXT_EVENT;
            default:       cnt_evt = 1'b0;
         endcase
         cnt_up = I_DIR_BY_PIN ? b_lvl : I_DIR_UP;
      end
   end

   // ---------------------------------------------
   // Counter, reload and output
   // ---------------------------------------------
   reg [15:0] count_reg;
   reg [15:0] count_next;
   reg [15:0] reload_reg;
   reg [15:0] reload_next;
   reg        started_reg;
   reg        started_next;
   reg        evt_reg;
   reg        pout_reg;
   reg        pout_next;
   reg        idx_arm_reg;
   reg        idx_arm_next;
   reg        idx_pend_reg;
   reg        idx_pend_next;

   wire run      = I_CHANNEL_RUN_BIT;
   wire tick     = run && cnt_evt;
   // Wrap is the count that passes the end: n+1 counts per underflow
   wire wrap     = tick && at_limit(count_reg, cnt_up);
   wire idx_edge = edge_pick(~I_INDEX_POL, z_rise, z_fall);
   wire idx_ok   = two_ph && (CHANNEL == `ECQ_CHAN_SELECT) &&
                   I_INDEX_CLEAR_ENABLE && idx_arm_reg;
   // A write racing a count event loses the counter to the event
   wire wr_count = I_WR_STB && !(run && started_reg) && !tick;

   // ---------------------------------------------
   // Start and index flags
   // ---------------------------------------------
   // Dropping the run bit forgets that counting had begun
   always @* begin
      started_next = started_reg;
      if (!run)
         started_next = 1'h0;
      else if (tick)
         started_next = 1'h1;
   end

   always @* begin
      idx_arm_next = idx_arm_reg;
      if (I_WR_STB)
         idx_arm_next = (I_WR_DATA == `ECQ_CNT_MIN);
   end

   // A new index edge wins over the clear in the same cycle;
   // leaving index mode drops a pending clear
   always @* begin
      idx_pend_next = idx_pend_reg;
      if (idx_ok && idx_edge)
         idx_pend_next = 1'h1;
      else if (tick || !idx_ok)
         idx_pend_next = 1'h0;
   end

   // ---------------------------------------------
   // Counter and reload
   // ---------------------------------------------
   // Every write reaches the reload register
   always @* begin
      reload_next = reload_reg;
      if (I_WR_STB)
         reload_next = I_WR_DATA;
   end

   // Early write first, then index clear, reload and plain step
   always @* begin
      count_next = count_reg;
      if (wr_count)
         count_next = I_WR_DATA;
      else if (tick && idx_pend_reg)
         count_next = `ECQ_CNT_MIN;
      else if (wrap && !I_FREE_RUN)
         count_next = reload_reg;
      else if (tick)
         count_next = count_step(count_reg, cnt_up);
   end

   // ---------------------------------------------
   // Pulse output
   // ---------------------------------------------
   // Held low while stopped, toggled on every wrap
   always @* begin
      pout_next = pout_reg;
      if (!run)
         pout_next = 1'h0;
      else if (wrap && I_PULSE_OUT_EN)
         pout_next = ~pout_reg;
   end

   // ---------------------------------------------
   // Register update
   // ---------------------------------------------
   always @(posedge I_CLOCK) begin
      if (I_RST) begin
         count_reg    <= `ECQ_CNT_RST;
         reload_reg   <= `ECQ_CNT_RST;
         started_reg  <= `ECQ_FLAG_RST;
         evt_reg      <= `ECQ_FLAG_RST;
         pout_reg     <= `ECQ_FLAG_RST;
         idx_arm_reg  <= `ECQ_FLAG_RST;
         idx_pend_reg <= `ECQ_FLAG_RST;
         x4_dir_reg   <= `ECQ_DIR_RST;
      end else begin
         count_reg    <= count_next;
         reload_reg   <= reload_next;
         started_reg  <= started_next;
         evt_reg      <= wrap;
         pout_reg     <= pout_next;
         idx_arm_reg  <= idx_arm_next;
         idx_pend_reg <= idx_pend_next;
         x4_dir_reg   <= x4_dir_next;
      end
   end

   assign O_COUNT_VALUE_REG = count_reg;
   assign O_RELOAD          = reload_reg;
   assign O_IRQ             = evt_reg;
   assign O_EVENT           = evt_reg;
   assign O_PULSE_OUT       = pout_reg;

endmodule

// File: rtl/ecq_sync.v
// Two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ps
module ecq_sync (
   input  wire i_clk,    // Clock
   input  wire i_rst,    // Synchronous reset, active high
   input  wire i_pin,    // Raw pin level
   output wire o_level,  // Synchronised level
   output wire o_rise,   // Rising edge pulse
   output wire o_fall    // Falling edge pulse
);

   reg meta_reg;
   reg sync_reg;
   reg last_reg;

   always @(posedge i_clk) begin
      if (i_rst) begin
         // Follow the pin so its idle level gives no edge after reset
         meta_reg <= i_pin;
         sync_reg <= i_pin;
         last_reg <= i_pin;
      end else begin
         meta_reg <= i_pin;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign o_level = sync_reg;
   assign o_rise  = sync_reg & ~last_reg;
   assign o_fall  = ~sync_reg & last_reg;

endmodule

// File: sim/ecq_counter_properties.sv
// Port assertions for the event counter channel
`timescale 1ns/1ps
module ecq_counter_properties (
   input wire        I_CLOCK,           // Clock
   input wire        I_RST,             // Reset, active high
   input wire        I_CHANNEL_RUN_BIT, // Run bit
   input wire        I_DIR_BY_PIN,      // Direction from aux pin
   input wire        I_DIR_UP,          // Software direction
   input wire        I_FREE_RUN,        // Free-running
   input wire        I_COMP_EVENT,      // Companion event
   input wire        I_WR_STB,          // Write strobe
   input wire        O_IRQ,             // Interrupt request
   input wire        O_PULSE_OUT,       // Pulse output
   input wire [1:0]  I_TRIGGER_SELECT,  // Count source
   input wire [15:0] I_WR_DATA,         // Write data
   input wire [15:0] O_COUNT_VALUE_REG, // Counter value
   input wire [15:0] O_RELOAD           // Reload value
);
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   wire dn = I_CHANNEL_RUN_BIT && I_TRIGGER_SELECT == 2'h1 && I_COMP_EVENT
      && !I_DIR_BY_PIN && !I_DIR_UP && !I_WR_STB;
   wire [15:0] cv = O_COUNT_VALUE_REG;
   sequence irq_soon;
      ##[0:1] O_IRQ;
   endsequence
   chk_pulse_low: assert property (!I_CHANNEL_RUN_BIT |=>
      !O_PULSE_OUT) else $error("pulse high while stopped");
   chk_pulse_toggle: assert property ($changed(O_PULSE_OUT)
      && $past(I_CHANNEL_RUN_BIT) && !$past(I_RST) |-> irq_soon)
      else $error("pulse toggled without wrap");
   chk_stop_hold: assert property (!$past(I_CHANNEL_RUN_BIT)
      && !$past(I_WR_STB) && !$past(I_RST) |-> $stable(cv))
      else $error("count moved while stopped");
   chk_stop_load: assert property (I_WR_STB && !I_CHANNEL_RUN_BIT |=>
      cv == $past(I_WR_DATA) && O_RELOAD == $past(I_WR_DATA))
      else $error("stopped write not loaded");
   chk_reload_write: assert property (I_WR_STB |=>
      O_RELOAD == $past(I_WR_DATA)) else $error("reload not written");
   chk_down_step: assert property (dn && cv != 16'h0000 |=>
      cv == $past(cv) - 16'h0001) else $error("down step wrong");
   chk_under_load: assert property (dn && cv == 16'h0000 && !I_FREE_RUN
      |=> cv == $past(O_RELOAD) ##0 irq_soon) else $error("reload wrong");
   chk_free_wrap: assert property (dn && cv == 16'h0000 && I_FREE_RUN |=>
      cv == 16'hffff ##0 irq_soon) else $error("free wrap wrong");
endmodule
bind ecq_counter ecq_counter_properties u_props (.I_CLOCK(I_CLOCK),
   .I_RST(I_RST), .I_CHANNEL_RUN_BIT(I_CHANNEL_RUN_BIT),
   .I_DIR_BY_PIN(I_DIR_BY_PIN), .I_DIR_UP(I_DIR_UP), .I_FREE_RUN(I_FREE_RUN),
   .I_COMP_EVENT(I_COMP_EVENT), .I_WR_STB(I_WR_STB), .O_IRQ(O_IRQ),
   .O_PULSE_OUT(O_PULSE_OUT), .I_TRIGGER_SELECT(I_TRIGGER_SELECT),
   .I_WR_DATA(I_WR_DATA), .O_COUNT_VALUE_REG(O_COUNT_VALUE_REG),
   .O_RELOAD(O_RELOAD));

// File: sim/ecq_counter_tb_top.sv
// Self-checking bench for the event counter channel
`timescale 1ns/1ps
module ecq_counter_tb_top;
   reg clk = 0, rst = 1, run = 0, dby = 0, dup = 0, frun = 0, two = 0;
   reg quad = 0, zen = 0, zp = 0, ce = 0, stb = 0, step = 0, up = 0, fe = 0;
   reg [1:0] trg = 2'h1;
   reg [15:0] wd = 16'h0000;
   wire [15:0] cnt, rld;
   wire irq, evt, po, pa, pb;
   integer bad_count = 0, tests_run = 0, irqs = 0, cyc_n = 0, evs = 0;
   ecq_counter #(.CHANNEL(3)) ecq_counter_inst (.I_CLOCK(clk), .I_RST(rst),
      .I_COUNT_INPUT_PIN(pa), .I_AUX_PHASE_PIN(pb), .I_INDEX_PIN(zp),
      .I_INDEX_POL(1'h1), .I_CHANNEL_RUN_BIT(run), .I_TRIGGER_SELECT(trg),
      .I_EDGE_FALLING(fe), .I_DIR_BY_PIN(dby), .I_DIR_UP(dup),
      .I_FREE_RUN(frun), .I_PULSE_OUT_EN(1'h1), .I_TWO_PHASE_ENABLE(two),
      .I_QUAD_MODE_SELECT(quad), .I_INDEX_CLEAR_ENABLE(zen),
      .I_COMP_EVENT(ce), .I_PREV_EVENT(1'h0), .I_NEXT_EVENT(1'h0),
      .I_WR_STB(stb), .I_WR_DATA(wd), .O_COUNT_VALUE_REG(cnt),
      .O_RELOAD(rld), .O_IRQ(irq), .O_EVENT(evt), .O_PULSE_OUT(po));
   ecq_encoder ecq_encoder_inst (.i_clk(clk), .i_step(step), .i_up(up),
      .o_pa(pa), .o_pb(pb));
   initial forever #10 clk = ~clk;
   task close_out;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (irq === 1'h1) irqs <= irqs + 1;
      if (evt === 1'h1) evs <= evs + 1;
      if (cyc_n == 3000) begin bad_count = bad_count + 1; close_out; end
   end
   task chk(input [15:0] s, input [15:0] e, input string nm);
      tests_run = tests_run + 1;
      if (s !== e) begin
         bad_count = bad_count + 1;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task cy(input integer n); repeat (n) @(negedge clk); endtask
   task wr(input [15:0] d);
      @(posedge clk) begin stb <= 1; wd <= d; end
      @(posedge clk) stb <= 0;
      cy(1);
   endtask
   task ev(input integer n);
      repeat (n) begin @(posedge clk) ce <= 1; @(posedge clk) ce <= 0; end
      cy(2);
   endtask
   task st(input u, input integer n);
      repeat (n) begin
         @(posedge clk) begin step <= 1; up <= u; end
         @(posedge clk) step <= 0;
         cy(4);
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      wr(16'h0002);
      chk(cnt, 16'h0002, "count");
      chk(rld, 16'h0002, "reload");
      @(posedge clk) run <= 1;
      ev(3);
      chk(cnt, 16'h0002, "count");
      chk(po, 16'h0001, "pulse");
      ev(1);
      wr(16'h0005);
      chk(cnt, 16'h0001, "count");
      chk(rld, 16'h0005, "reload");
      ev(2);
      chk(cnt, 16'h0005, "count");
      $display("test reload done");
      @(posedge clk) begin run <= 0; frun <= 1; end
      wr(16'h0000);
      @(posedge clk) run <= 1;
      ev(1);
      chk(cnt, 16'hffff, "count");
      @(posedge clk) run <= 0;
      ev(1);
      chk(cnt, 16'hffff, "count");
      chk(po, 16'h0000, "pulse");
      @(posedge clk) begin run <= 1; dup <= 1; end
      ev(1);
      chk(cnt, 16'h0000, "count");
      chk(irqs[15:0], 16'h0004, "irqs");
      chk(evs[15:0], 16'h0004, "events");
      $display("test free run done");
      @(posedge clk) begin trg <= 0; dby <= 1; dup <= 0; end
      st(1, 4);
      chk(cnt, 16'h0001, "count");
      @(posedge clk) fe <= 1;
      st(1, 4);
      chk(cnt, 16'h0000, "count");
      $display("test pin done");
      @(posedge clk) run <= 0;
      wr(16'h0000);
      @(posedge clk) begin run <= 1; two <= 1; quad <= 1; zen <= 1; end
      st(1, 6);
      chk(cnt, 16'h0006, "count");
      st(0, 2);
      chk(cnt, 16'h0004, "count");
      @(posedge clk) zp <= 1;
      st(0, 1);
      chk(cnt, 16'h0000, "count");
      @(posedge clk) begin zp <= 0; quad <= 0; end
      st(1, 4);
      chk(cnt, 16'h0001, "count");
      $display("test two phase done");
      close_out;
   end
endmodule

// File: sim/ecq_encoder.sv
// Two-phase encoder model driving the count and aux pins
`timescale 1ns/1ps
module ecq_encoder (
   input  wire i_clk,  // Clock
   input  wire i_step, // Advance one quarter step
   input  wire i_up,   // 1 forward
   output wire o_pa,   // Count input phase
   output wire o_pb    // Aux phase
);
   reg [1:0] pos_reg = 2'h0;
   // Gray order: forward, a rises while b is high
   assign o_pa = pos_reg[1];
   assign o_pb = ^pos_reg;
   always @(posedge i_clk) begin
      if (i_step) pos_reg <= i_up ? pos_reg + 2'h1 : pos_reg - 2'h1;
   end
endmodule
